// ===== src/fpc_flyback_protection_control.sv
/*
 * Flyback gate gating and fault control: current limit with blanking, overload and
 * short-circuit timing, supply and auxiliary overvoltage, over-temperature, external latch.
 * Assumes all inputs but the two latch-mode selects are comparator outputs from outside the clock domain, and that
 * the timing capacitor comparator toggles once per timer clock.
 */
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////////////////////
// Function
// - Sense above limit ends gate pulse
// - Compensation current on high line, high comp
// - Ignore sense 350 ns after turn-on
// - Auto-recovery: retry at each lockout-on
// - Latch mode: clear only via power-down-clear
// - Comp high past overload delay trips
// - Overload delay counts timer capacitor clocks
// - Timer sets overload debounce, 64 ticks
// - Overload releases on fourth lockout-off
// - Comp high 16 ms, low supply trips
// - Supply overvoltage stops gate at once
// - Aux falling edge starts gate pulse
// - Sample aux overvoltage 3 us after turn-off
// - Sample over 300 uA is event
// - Four consecutive events switch gate off
// - Over-temperature disables gate with hysteresis
// - External pin low latches off
// - External latch clears via power-down-clear
module fpc_flyback_protection_control
    import fpc_pkg::*;
#(
    parameter int SHORT_CYC = SHORT_CYC_DEF,
    parameter int OVERLOAD_TICKS = OVERLOAD_TICKS_DEF
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic currentSenseOverLimit,
    input wire logic feedbackCompAboveComp,
    input wire logic feedbackCompOverload,
    input wire logic auxWindingZeroCross,
    input wire logic auxOvercurrentSample,
    input wire logic highLineDetect,
    input wire logic supplyLockoutOn,
    input wire logic supplyLockoutOff,
    input wire logic powerDownClear,
    input wire logic supplyBelowShortLevel,
    input wire logic supplyOvervoltage,
    input wire logic overTemperature,
    input wire logic externalFaultLow,
    input wire logic timerCapInput,
    input wire logic supplyOvLatchMode,
    input wire logic auxOvLatchMode,
    output logic flybackGateOut,
    output logic compCurrentEnable,
    output logic faultActive
);

    //////////////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers.

    logic [SYNC_W-1:0] rawIn;
    logic [SYNC_W-1:0] syncIn;

    assign rawIn = {currentSenseOverLimit, feedbackCompAboveComp, feedbackCompOverload,
                    auxWindingZeroCross, auxOvercurrentSample, highLineDetect,
                    supplyLockoutOn, supplyLockoutOff, powerDownClear,
                    supplyOvervoltage, timerCapInput};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            fpc_sync u_sync (
                .clk(clk),
                .reset(reset),
                .din(rawIn[gi]),
                .dout(syncIn[gi])
            );
        end
    endgenerate

    logic senseHigh;
    logic compAbove;
    logic compOverload;
    logic auxHigh;
    logic auxOv;
    logic highLine;
    logic lockOn;
    logic lockOff;
    logic pdClear;
    logic supplyOv;
    logic timerIn;
    logic supplyLow;
    logic hotChip;
    logic extLow;

    assign {senseHigh, compAbove, compOverload, auxHigh, auxOv, highLine,
            lockOn, lockOff, pdClear, supplyOv, timerIn} = syncIn;

    fpc_sync u_sync_low (.clk(clk), .reset(reset), .din(supplyBelowShortLevel),
                         .dout(supplyLow));
    fpc_sync u_sync_hot (.clk(clk), .reset(reset), .din(overTemperature), .dout(hotChip));
    fpc_sync u_sync_ext (.clk(clk), .reset(reset), .din(externalFaultLow), .dout(extLow));

    //////////////////////////////////////////////////////////////////////////////////////////
    // State.

    typedef enum logic [1:0] {GATE_IDLE, GATE_ON, GATE_OFF_WAIT} fpc_gate_type;

    typedef struct packed {
        fpc_gate_type gate;
        logic gateOut;
        logic compEn;
        logic faultOut;
        logic [TIM_W-1:0] blankCnt;
        logic [TIM_W-1:0] sampleCnt;
        logic [CNT_W-1:0] shortCnt;
        logic [7:0] olTicks;
        logic timerPrev;
        logic auxPrev;
        logic lockOnPrev;
        logic lockOffPrev;
        logic [2:0] auxOvCnt;
        logic [1:0] restartCnt;
        logic overloadLatch;
        logic autoLatch;
        logic hardLatch;
        logic pdSeen;
    } fpc_state_type;

    fpc_state_type st_r;
    fpc_state_type st_nxt;

    logic lockOnRise;
    logic lockOffRise;
    logic timerTick;
    logic auxFall;
    logic gateBlocked;

    assign lockOnRise = lockOn && !st_r.lockOnPrev;
    assign lockOffRise = lockOff && !st_r.lockOffPrev;
    assign timerTick = timerIn && !st_r.timerPrev;
    assign auxFall = !auxHigh && st_r.auxPrev;
    // Over-temperature is not latched; the front end supplies the hysteresis.
    assign gateBlocked = st_r.overloadLatch || st_r.autoLatch || st_r.hardLatch || hotChip
                         || supplyOv;

    //////////////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        st_nxt = st_r;
        st_nxt.timerPrev = timerIn;
        st_nxt.auxPrev = auxHigh;
        st_nxt.lockOnPrev = lockOn;
        st_nxt.lockOffPrev = lockOff;
        st_nxt.compEn = highLine && compAbove;

        // Overload debounce counts timer ticks while comp stays high.
        if (!compOverload) begin
            st_nxt.olTicks = 8'h00;
        end else if (timerTick && st_r.olTicks < 8'(OVERLOAD_TICKS)) begin
            st_nxt.olTicks = st_r.olTicks + 8'h01;
        end

        if (!(compOverload && supplyLow)) begin
            st_nxt.shortCnt = '0;
        end else if (st_r.shortCnt < CNT_W'(SHORT_CYC)) begin
            st_nxt.shortCnt = st_r.shortCnt + 1'b1;
        end

        // Overload: latched until the fourth lockout-off event.
        if (st_r.olTicks >= 8'(OVERLOAD_TICKS) && !st_r.overloadLatch) begin
            st_nxt.overloadLatch = 1'b1;
            st_nxt.restartCnt = 2'h0;
        end else if (st_r.overloadLatch && lockOffRise) begin
            if (st_r.restartCnt == RESTART_LAST) begin
                st_nxt.overloadLatch = 1'b0;
                st_nxt.olTicks = 8'h00;
            end else begin
                st_nxt.restartCnt = st_r.restartCnt + 2'h1;
            end
        end

        // Auto-recovery latch retries on lockout-on; set wins over clear.
        if (lockOnRise) begin
            st_nxt.autoLatch = 1'b0;
        end
        if (st_r.pdSeen && lockOnRise) begin
            st_nxt.hardLatch = 1'b0;
            st_nxt.pdSeen = 1'b0;
        end
        if (pdClear && st_r.hardLatch) begin
            st_nxt.pdSeen = 1'b1;
        end

        if (st_r.shortCnt >= CNT_W'(SHORT_CYC)) begin
            st_nxt.autoLatch = 1'b1;
        end
        if (supplyOv) begin
            if (supplyOvLatchMode) begin
                st_nxt.hardLatch = 1'b1;
            end else begin
                st_nxt.autoLatch = 1'b1;
            end
        end
        if (extLow) begin
            st_nxt.hardLatch = 1'b1;
        end

        // Gate pulse sequencing.
        st_nxt.gateOut = 1'b0;
        case (st_r.gate)
            GATE_IDLE: begin
                if (auxFall && !gateBlocked) begin
                    st_nxt.gate = GATE_ON;
                    st_nxt.blankCnt = '0;
                    st_nxt.gateOut = 1'b1;
                end
            end
            GATE_ON: begin
                st_nxt.gateOut = 1'b1;
                if (st_r.blankCnt < TIM_W'(BLANK_CYC)) begin
                    st_nxt.blankCnt = st_r.blankCnt + 1'b1;
                end
                if (gateBlocked || (senseHigh && st_r.blankCnt >= TIM_W'(BLANK_CYC))) begin
                    st_nxt.gate = GATE_OFF_WAIT;
                    st_nxt.gateOut = 1'b0;
                    st_nxt.sampleCnt = '0;
                end
            end
            GATE_OFF_WAIT: begin
                st_nxt.sampleCnt = st_r.sampleCnt + 1'b1;
                if (st_r.sampleCnt >= TIM_W'(AUX_SAMPLE_CYC - 1)) begin
                    st_nxt.gate = GATE_IDLE;
                    if (auxOv) begin
                        st_nxt.auxOvCnt = st_r.auxOvCnt + 3'h1;
                        if (st_r.auxOvCnt + 3'h1 >= AUX_OV_LAST) begin
                            st_nxt.auxOvCnt = 3'h0;
                            if (auxOvLatchMode) begin
                                st_nxt.hardLatch = 1'b1;
                            end else begin
                                st_nxt.autoLatch = 1'b1;
                            end
                        end
                    end else begin
                        st_nxt.auxOvCnt = 3'h0;
                    end
                end
            end
            default: begin
                st_nxt.gate = GATE_IDLE;
            end
        endcase

        st_nxt.faultOut = st_nxt.overloadLatch || st_nxt.autoLatch || st_nxt.hardLatch;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign flybackGateOut = st_r.gateOut;
    assign compCurrentEnable = st_r.compEn;
    assign faultActive = st_r.faultOut;

    //////////////////////////////////////////////////////////////////////////////////////////
    // Checks.

    // A fault may still end a pulse inside the window; only the sense input is masked.
    gate_blank_a: assert property (@(posedge clk) disable iff (reset)
        (st_r.gate == GATE_ON && st_r.blankCnt < TIM_W'(BLANK_CYC) && !gateBlocked)
        |=> st_r.gateOut)
        else $error("gate ended inside the blanking window");

    sense_stop_a: assert property (@(posedge clk) disable iff (reset)
        (st_r.gate == GATE_ON && senseHigh && st_r.blankCnt >= TIM_W'(BLANK_CYC))
        |=> !st_r.gateOut)
        else $error("gate not ended by current limit");

    comp_enable_a: assert property (@(posedge clk) disable iff (reset)
        (highLine && compAbove) |=> compCurrentEnable)
        else $error("compensation current not enabled");

    supply_ov_a: assert property (@(posedge clk) disable iff (reset)
        supplyOv |=> !flybackGateOut)
        else $error("gate on during supply overvoltage");

    hot_off_a: assert property (@(posedge clk) disable iff (reset)
        hotChip |=> !flybackGateOut)
        else $error("gate on while over temperature");

    ext_latch_a: assert property (@(posedge clk) disable iff (reset)
        extLow |=> st_r.hardLatch && faultActive)
        else $error("external fault did not latch");

    aux_clear_a: assert property (@(posedge clk) disable iff (reset)
        (st_r.gate == GATE_OFF_WAIT && st_r.sampleCnt >= TIM_W'(AUX_SAMPLE_CYC - 1) && !auxOv)
        |=> st_r.auxOvCnt == 3'h0)
        else $error("aux event counter not cleared");

    overload_hold_a: assert property (@(posedge clk) disable iff (reset)
        (st_r.overloadLatch && !(lockOffRise && st_r.restartCnt == RESTART_LAST))
        |=> st_r.overloadLatch)
        else $error("overload released early");

    latch_hold_a: assert property (@(posedge clk) disable iff (reset)
        (st_r.hardLatch && !st_r.pdSeen) |=> st_r.hardLatch)
        else $error("latch cleared without power-down-clear");

    aux_start_a: assert property (@(posedge clk) disable iff (reset)
        $rose(st_r.gateOut) |-> $past(auxFall))
        else $error("gate started without zero crossing");

endmodule
`default_nettype wire

// ===== src/fpc_pkg.sv
/*
 * Constants for the flyback protection control block: timing counts, event counts and widths.
 * Assumes a 100 MHz system clock and comparator outputs from an analog front end.
 */
package fpc_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int BLANK_NS = 350;
    localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int AUX_SAMPLE_NS = 3000;
    localparam int AUX_SAMPLE_CYC = (AUX_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SHORT_MS = 16;
    localparam int SHORT_CYC_DEF = SHORT_MS * 100000;
    localparam int OVERLOAD_TICKS_DEF = 64;
    localparam int RESTART_COUNT = 4;
    localparam int AUX_OV_COUNT = 4;
    localparam logic [1:0] RESTART_LAST = 2'h3;
    localparam logic [2:0] AUX_OV_LAST = 3'h4;
    localparam int CNT_W = 24;
    localparam int TIM_W = 12;
    localparam int SYNC_W = 11;
endpackage

// ===== src/fpc_sync.sv
/*
 * Three-stage synchroniser with agreement filter for one asynchronous level.
 * Assumes the input is a slow comparator or pin level.
 */
`timescale 1ns/1ps
`default_nettype none
module fpc_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic din,
    output logic dout
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic out_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            out_r <= 1'b0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // A change counts only when the second and third stages agree.
            if (s2_r == s3_r) begin
                out_r <= s3_r;
            end
        end
    end

    assign dout = out_r;
endmodule
`default_nettype wire

// ===== verif/fpc_front_model.sv
/*
 * Front-end model: switch current ramp, auxiliary winding ringing and aux sink level.
 * Assumes the gate output of the block is its only stimulus besides two bench knobs.
 */
`timescale 1ns/1ps
`default_nettype none
module fpc_front_model (
    input wire logic clk,
    input wire logic flybackGateOut,
    input wire logic [7:0] senseDelay,
    input wire logic ovLevel,
    output logic currentSenseOverLimit,
    output logic auxWindingZeroCross,
    output logic auxOvercurrentSample
);
    logic [9:0] onCnt_r;
    logic [9:0] offCnt_r;
    initial onCnt_r = 10'h0;
    initial offCnt_r = 10'h0;
    always @(posedge clk) begin
        onCnt_r <= flybackGateOut ? onCnt_r + 10'h1 : 10'h0;
        offCnt_r <= (flybackGateOut || offCnt_r == 10'h257) ? 10'h0 : offCnt_r + 10'h1;
    end
    // The ramp crosses the limit a set time into the pulse and vanishes at turn-off.
    assign currentSenseOverLimit = flybackGateOut && onCnt_r >= {2'h0, senseDelay};
    // Ringing repeats while the switch stays off, so a cleared fault can restart.
    assign auxWindingZeroCross = !flybackGateOut && offCnt_r < 10'h190;
    // Sink current flows only in the off-time, which is when it may be sampled.
    assign auxOvercurrentSample = ovLevel && !flybackGateOut;
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
/*
 * Self-checking bench for the flyback protection control block.
 * Assumes the front-end model in fpc_front_model.sv and shortened timing parameters.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin error_cnt++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module tb_top
    import fpc_pkg::*;
;
    localparam int OL_TICKS = 4;
    logic clk, reset, feedbackCompAboveComp, feedbackCompOverload, highLineDetect;
    logic supplyLockoutOn, supplyLockoutOff, powerDownClear, supplyBelowShortLevel;
    logic supplyOvervoltage, overTemperature, externalFaultLow, timerCapInput;
    logic supplyOvLatchMode, auxOvLatchMode, ovLevel;
    logic currentSenseOverLimit, auxWindingZeroCross, auxOvercurrentSample;
    logic flybackGateOut, compCurrentEnable, faultActive;
    logic [7:0] senseDelay;
    int error_cnt, check_count, len;
    fpc_flyback_protection_control #(.SHORT_CYC(200), .OVERLOAD_TICKS(OL_TICKS)) dut_u (
        .clk, .reset, .currentSenseOverLimit, .feedbackCompAboveComp, .feedbackCompOverload,
        .auxWindingZeroCross, .auxOvercurrentSample, .highLineDetect, .supplyLockoutOn,
        .supplyLockoutOff, .powerDownClear, .supplyBelowShortLevel, .supplyOvervoltage,
        .overTemperature, .externalFaultLow, .timerCapInput, .supplyOvLatchMode,
        .auxOvLatchMode, .flybackGateOut, .compCurrentEnable, .faultActive);
    fpc_front_model model_u (.clk, .flybackGateOut, .senseDelay, .ovLevel,
        .currentSenseOverLimit, .auxWindingZeroCross, .auxOvercurrentSample);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rise();
        for (int w = 0; w < 1300 && !flybackGateOut; w++) tick(1);
    endtask
    task automatic on_len();
        rise();
        for (len = 0; len < 400 && flybackGateOut; len++) tick(1);
    endtask
    // Passes one sample point: end of the pulse, 3 us plus margin, then the next start.
    task automatic cyc();
        for (int w = 0; w < 400 && flybackGateOut; w++) tick(1);
        tick(320);
        rise();
    endtask
    task automatic sw(input logic ex, input string nm);
        logic seen;
        seen = 1'b0;
        repeat (1300) begin
            tick(1);
            seen |= flybackGateOut;
        end
        `CHK(nm, ex, seen)
    endtask
    // Events are rising edges, held long enough to pass the input filter.
    task automatic pulse(input int k);
        case (k)
            0: supplyLockoutOn = 1'b1;
            1: supplyLockoutOff = 1'b1;
            2: powerDownClear = 1'b1;
            default: timerCapInput = 1'b1;
        endcase
        tick(6);
        {supplyLockoutOn, supplyLockoutOff, powerDownClear, timerCapInput} = 4'h0;
        tick(6);
    endtask
    task automatic drop(input int k);
        rise();
        case (k)
            0: supplyOvervoltage = 1'b1;
            1: overTemperature = 1'b1;
            default: externalFaultLow = 1'b1;
        endcase
        tick(6);
        `CHK("gateDrop", 1'b0, flybackGateOut)
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic t_pulse();
        senseDelay = 8'h0a;
        on_len();
        on_len();
        `CHK("blankLen", 1'b1, len >= BLANK_CYC - 1 && len <= BLANK_CYC + 6)
        senseDelay = 8'h50;
        on_len();
        on_len();
        `CHK("limitLen", 1'b1, len >= 80 && len <= 90)
    endtask
    task automatic t_comp();
        for (int i = 0; i < 4; i++) begin
            {highLineDetect, feedbackCompAboveComp} = 2'(i);
            tick(8);
            `CHK("compEn", i == 3, compCurrentEnable)
        end
    endtask
    task automatic t_supply_ov(input logic latch);
        supplyOvLatchMode = latch;
        drop(0);
        supplyOvervoltage = 1'b0;
        sw(1'b0, "ovHeld");
        pulse(0);
        sw(~latch, "ovRetry");
        pulse(2);
        pulse(0);
        sw(1'b1, "ovRepower");
    endtask
    task automatic t_hot_ext();
        drop(1);
        sw(1'b0, "hotOff");
        overTemperature = 1'b0;
        sw(1'b1, "hotCool");
        drop(2);
        `CHK("extFault", 1'b1, faultActive)
        externalFaultLow = 1'b0;
        pulse(0);
        sw(1'b0, "extHeld");
        pulse(2);
        pulse(0);
        sw(1'b1, "extClear");
    endtask
    task automatic t_overload();
        feedbackCompOverload = 1'b1;
        tick(100);
        repeat (OL_TICKS - 1) pulse(3);
        `CHK("olEarly", 1'b0, faultActive)
        pulse(3);
        `CHK("olTrip", 1'b1, faultActive)
        feedbackCompOverload = 1'b0;
        repeat (RESTART_COUNT - 1) pulse(1);
        sw(1'b0, "olHeld");
        pulse(1);
        sw(1'b1, "olFree");
    endtask
    task automatic t_short();
        {feedbackCompOverload, supplyBelowShortLevel} = 2'h3;
        tick(150);
        `CHK("shortEarly", 1'b0, faultActive)
        tick(70);
        `CHK("shortTrip", 1'b1, faultActive)
        {feedbackCompOverload, supplyBelowShortLevel} = 2'h0;
        // Let the short counter clear first, or the retry edge meets a fresh set.
        tick(10);
        pulse(0);
        sw(1'b1, "shortClear");
    endtask
    task automatic t_aux_ov(input logic latch);
        auxOvLatchMode = latch;
        rise();
        ovLevel = 1'b1;
        repeat (AUX_OV_COUNT - 1) cyc();
        ovLevel = 1'b0;
        cyc();
        ovLevel = 1'b1;
        repeat (AUX_OV_COUNT - 1) cyc();
        `CHK("auxRun", 1'b0, faultActive)
        cyc();
        `CHK("auxTrip", 2'h1, {flybackGateOut, faultActive})
        ovLevel = 1'b0;
        pulse(0);
        sw(~latch, "auxRetry");
        pulse(2);
        pulse(0);
        sw(1'b1, "auxClear");
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #800us;
        error_cnt++;
        give_verdict();
    end
    initial begin
        {feedbackCompAboveComp, feedbackCompOverload, highLineDetect, supplyLockoutOn,
         supplyLockoutOff, powerDownClear, supplyBelowShortLevel, supplyOvervoltage,
         overTemperature, externalFaultLow, timerCapInput, supplyOvLatchMode,
         auxOvLatchMode, ovLevel} = '0;
        senseDelay = 8'h50;
        reset = 1'b1;
        tick(3);
        `CHK("rstOut", 3'h0, {flybackGateOut, compCurrentEnable, faultActive})
        reset = 1'b0;
        sw(1'b1, "start");
        t_pulse();
        t_comp();
        t_supply_ov(1'b0);
        t_supply_ov(1'b1);
        t_hot_ext();
        t_overload();
        t_short();
        t_aux_ov(1'b0);
        t_aux_ov(1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire
